// >>> acs_clock_sampler.sv
// Operating clock, output clock, data sampling and monitor timing
`timescale 1ns/1ps
`default_nettype none
module acs_clock_sampler #(
    parameter int DATA_W = acs_pkg::DATA_W,
    parameter int FIFO_DEPTH = acs_pkg::FIFO_DEPTH,
    parameter int unsigned MONITOR_CYCLES = acs_pkg::MONITOR_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Configuration, taken on cfg_apply while idle
    input wire logic cfg_apply,
    input wire logic cfg_int_clk,
    input wire logic [acs_pkg::DIV_W-1:0] cfg_div_ratio,
    input wire logic [acs_pkg::FREQ_W-1:0] cfg_freq_khz,
    input wire logic cfg_force_pll_off,
    input wire logic cfg_fall_sample,
    input wire logic cfg_out_en,
    input wire logic [acs_pkg::RATIO_W-1:0] cfg_out_ratio,
    input wire logic cfg_out_invert,
    input wire logic [DATA_W-1:0] cfg_data_mask,
    input wire logic cfg_ext_trig_en,
    // Job control
    input wire logic capture_run,
    input wire logic monitor_run,
    // Connector pins
    input wire logic [acs_pkg::REV_W-1:0] hw_rev,
    input wire logic [DATA_W-1:0] data_pin_in,
    output logic [DATA_W-1:0] data_pin_oe_n,
    input wire logic dedicated_clock_input_pin,
    input wire logic rev1_ext_clock_input_line,
    output logic dedicated_clock_output_pin,
    output logic dedicated_clock_output_oe_n,
    output logic rev1_clock_output_line,
    output logic rev1_clock_output_oe_n,
    // Status
    output logic pll_enable,
    output logic trig_enable,
    output logic rev1_dedicated_clock_input_pin_reserved,
    output logic rev1_dedicated_clock_output_pin_reserved,
    output logic busy,
    output logic overflow,
    // Sample stream
    output logic smp_valid,
    output logic [DATA_W-1:0] smp_data,
    input wire logic smp_ready
);
    localparam int DW = acs_pkg::DIV_W;
    localparam int RW = acs_pkg::RATIO_W;
    localparam int MW = $clog2(MONITOR_CYCLES + 1);
    localparam logic [MW-1:0] MON_LAST = MW'(MONITOR_CYCLES - 1);

    acs_pkg::acs_state_e state_q;
    logic int_clk_q;
    logic [DW-1:0] div_q;
    logic fall_q;
    logic out_en_q;
    logic [RW-1:0] oratio_q;
    logic inv_q;
    logic [DATA_W-1:0] mask_q;
    logic trig_cfg_q;
    logic [acs_pkg::REV_W-1:0] rev_q;
    logic pll_q;
    logic [acs_pkg::REV_W-1:0] rev_s1_q;
    logic [acs_pkg::REV_W-1:0] rev_s2_q;
    logic [DATA_W-1:0] d_s1_q;
    logic [DATA_W-1:0] d_s2_q;
    logic [1:0] ck_s1_q;
    logic [1:0] ck_s2_q;
    logic ck_s3_q;
    logic [DW-1:0] dcnt_q;
    logic [RW-1:0] ocnt_q;
    logic [RW-1:0] ocnt_nxt;
    logic ock_q;
    logic [MW-1:0] mon_cnt_q;
    logic ovf_q;
    logic dck_q;
    logic dck_oe_n_q;
    logic r1ck_q;
    logic r1ck_oe_n_q;
    logic is_rev1;
    logic idle;
    logic op_rise;
    logic op_fall;
    logic smp_edge;
    logic oedge;
    logic oother;
    logic ext_ck;
    logic push;

    acs_stream_if #(.W(DATA_W)) wr_if ();
    acs_stream_if #(.W(DATA_W)) rd_if ();

    assign idle = (state_q == acs_pkg::ACS_IDLE);
    assign is_rev1 = (rev_q == acs_pkg::REV_FIRST);

    // Job state machine
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= acs_pkg::ACS_IDLE;
        end else begin
            unique case (state_q)
                acs_pkg::ACS_IDLE: begin
                    if (monitor_run) begin
                        state_q <= acs_pkg::ACS_MONITOR;
                    end else if (capture_run) begin
                        state_q <= acs_pkg::ACS_CAPTURE;
                    end
                end
                acs_pkg::ACS_CAPTURE: begin
                    if (!capture_run) begin
                        state_q <= acs_pkg::ACS_IDLE;
                    end
                end
                acs_pkg::ACS_MONITOR: begin
                    if (!monitor_run) begin
                        state_q <= acs_pkg::ACS_IDLE;
                    end
                end
                default: begin
                    state_q <= acs_pkg::ACS_IDLE;
                end
            endcase
        end
    end

    // Pin synchronisers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rev_s1_q <= acs_pkg::REV_RESET;
            rev_s2_q <= acs_pkg::REV_RESET;
            d_s1_q <= '0;
            d_s2_q <= '0;
            ck_s1_q <= 2'h0;
            ck_s2_q <= 2'h0;
            ck_s3_q <= 1'b0;
        end else begin
            rev_s1_q <= hw_rev;
            rev_s2_q <= rev_s1_q;
            d_s1_q <= data_pin_in;
            d_s2_q <= d_s1_q;
            ck_s1_q <= {rev1_ext_clock_input_line, dedicated_clock_input_pin};
            ck_s2_q <= ck_s1_q;
            ck_s3_q <= ext_ck;
        end
    end

    // Both clock pins are synchronised before the revision select picks one
    assign ext_ck = is_rev1 ? ck_s2_q[1] : ck_s2_q[0];

    // Configuration registers, only loaded while idle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            int_clk_q <= 1'b1;
            div_q <= acs_pkg::DIV_RESET;
            fall_q <= 1'b0;
            out_en_q <= 1'b0;
            oratio_q <= acs_pkg::RATIO_RESET;
            inv_q <= 1'b0;
            mask_q <= acs_pkg::MASK_RESET;
            trig_cfg_q <= 1'b0;
            rev_q <= acs_pkg::REV_RESET;
            pll_q <= 1'b0;
        end else if (cfg_apply && idle) begin
            int_clk_q <= cfg_int_clk;
            div_q <= (cfg_div_ratio < acs_pkg::DIV_MIN) ? acs_pkg::DIV_MIN : cfg_div_ratio;
            fall_q <= cfg_fall_sample;
            out_en_q <= cfg_out_en;
            oratio_q <= (cfg_out_ratio == '0) ? acs_pkg::RATIO_RESET : cfg_out_ratio;
            inv_q <= cfg_out_invert;
            mask_q <= cfg_data_mask;
            trig_cfg_q <= cfg_ext_trig_en;
            rev_q <= rev_s2_q;
            pll_q <= !cfg_force_pll_off && (cfg_freq_khz >= acs_pkg::PLL_MIN_KHZ);
        end
    end

    // Internal operating clock divider, one sys_clk step per count
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dcnt_q <= '0;
        end else if (!int_clk_q || dcnt_q >= div_q - DW'(1)) begin
            dcnt_q <= '0;
        end else begin
            dcnt_q <= dcnt_q + DW'(1);
        end
    end

    // Operating clock edges: divider or external clock directly
    always_comb begin
        if (int_clk_q) begin
            op_rise = (dcnt_q >= div_q - DW'(1));
            op_fall = (dcnt_q == (div_q >> 1) - DW'(1));
        end else begin
            op_rise = ext_ck && !ck_s3_q;
            op_fall = !ext_ck && ck_s3_q;
        end
    end

    assign smp_edge = fall_q ? op_fall : op_rise;
    assign oedge = inv_q ? op_fall : op_rise;
    assign oother = inv_q ? op_rise : op_fall;
    assign ocnt_nxt = (ocnt_q >= oratio_q - RW'(1)) ? '0 : ocnt_q + RW'(1);

    // Output clock generator
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ocnt_q <= '0;
            ock_q <= 1'b0;
        end else if (!out_en_q) begin
            ocnt_q <= '0;
            ock_q <= 1'b0;
        end else if (oratio_q == RW'(1)) begin
            if (oedge) begin
                ock_q <= 1'b1;
            end else if (oother) begin
                ock_q <= 1'b0;
            end
        end else if (oedge) begin
            ocnt_q <= ocnt_nxt;
            ock_q <= (ocnt_nxt < (oratio_q >> 1));
        end
    end

    // Clock output pins
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dck_q <= 1'b0;
            dck_oe_n_q <= 1'b1;
            r1ck_q <= 1'b0;
            r1ck_oe_n_q <= 1'b1;
        end else begin
            dck_q <= out_en_q && !is_rev1 && ock_q;
            dck_oe_n_q <= !(out_en_q && !is_rev1);
            r1ck_q <= out_en_q && is_rev1 && ock_q;
            r1ck_oe_n_q <= !(out_en_q && is_rev1);
        end
    end

    // Monitor interval timer
    always_ff @(posedge sys_clk) begin
        if (reset || state_q != acs_pkg::ACS_MONITOR) begin
            mon_cnt_q <= '0;
        end else if (mon_cnt_q == MON_LAST) begin
            mon_cnt_q <= '0;
        end else begin
            mon_cnt_q <= mon_cnt_q + MW'(1);
        end
    end

    always_comb begin
        push = 1'b0;
        unique case (state_q)
            acs_pkg::ACS_CAPTURE: push = smp_edge;
            acs_pkg::ACS_MONITOR: push = (mon_cnt_q == MON_LAST);
            default: push = 1'b0;
        endcase
    end

    assign wr_if.valid = push;
    assign wr_if.data = d_s2_q & mask_q;
    assign rd_if.ready = smp_ready;

    acs_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(sys_clk),
        .reset(reset),
        .wr(wr_if.consumer),
        .rd(rd_if.producer)
    );

    // Overflow flag, set wins over clear
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ovf_q <= 1'b0;
        end else if (push && !wr_if.ready) begin
            ovf_q <= 1'b1;
        end else if (cfg_apply && idle) begin
            ovf_q <= 1'b0;
        end
    end

    // Status outputs
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pll_enable <= 1'b0;
            trig_enable <= 1'b0;
            rev1_dedicated_clock_input_pin_reserved <= 1'b0;
            rev1_dedicated_clock_output_pin_reserved <= 1'b0;
            busy <= 1'b0;
            data_pin_oe_n <= '1;
        end else begin
            pll_enable <= pll_q;
            trig_enable <= trig_cfg_q && state_q != acs_pkg::ACS_MONITOR;
            rev1_dedicated_clock_input_pin_reserved <= is_rev1 && !int_clk_q;
            rev1_dedicated_clock_output_pin_reserved <= is_rev1 && out_en_q;
            busy <= !idle;
            data_pin_oe_n <= '1;
        end
    end

    assign overflow = ovf_q;
    assign dedicated_clock_output_pin = dck_q;
    assign dedicated_clock_output_oe_n = dck_oe_n_q;
    assign rev1_clock_output_line = r1ck_q;
    assign rev1_clock_output_oe_n = r1ck_oe_n_q;
    assign smp_valid = rd_if.valid;
    assign smp_data = rd_if.data;
endmodule
`default_nettype wire

// >>> acs_clock_sampler_monitor.sv
// Assertion checker for the clock and sampling block
`timescale 1ns/1ps
`default_nettype none
module acs_clock_sampler_monitor #(
    parameter int unsigned MONITOR_CYCLES = acs_pkg::MONITOR_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Configuration and jobs
    input wire logic cfg_apply,
    input wire logic cfg_int_clk,
    input wire logic [acs_pkg::FREQ_W-1:0] cfg_freq_khz,
    input wire logic cfg_force_pll_off,
    input wire logic cfg_out_en,
    input wire logic capture_run,
    input wire logic monitor_run,
    // Pins
    input wire logic [acs_pkg::REV_W-1:0] hw_rev,
    input wire logic [acs_pkg::DATA_W-1:0] data_pin_oe_n,
    input wire logic dedicated_clock_output_oe_n,
    input wire logic rev1_clock_output_oe_n,
    // Status and stream
    input wire logic pll_enable,
    input wire logic trig_enable,
    input wire logic rev1_dedicated_clock_input_pin_reserved,
    input wire logic rev1_dedicated_clock_output_pin_reserved,
    input wire logic busy,
    input wire logic smp_valid,
    input wire logic smp_ready
);
    logic run_q;
    logic mon_q;
    logic [31:0] cnt_q;
    logic hs;
    logic idle_apply;
    logic pll_want;
    logic rev1_pin;

    assign pll_want = !cfg_force_pll_off && (cfg_freq_khz >= acs_pkg::PLL_MIN_KHZ);
    assign rev1_pin = (hw_rev == acs_pkg::REV_FIRST);

    assign hs = smp_valid && smp_ready;
    assign idle_apply = cfg_apply && !busy && !run_q && !capture_run && !monitor_run;

    // Cycles since the last accepted sample, and whether a sample was accepted during this monitor run
    always_ff @(posedge sys_clk) begin
        run_q <= capture_run || monitor_run;
        cnt_q <= (reset || hs) ? 32'h0 : cnt_q + 32'h1;
        mon_q <= !reset && monitor_run && (mon_q || hs);
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_data_undriven: assert property (data_pin_oe_n == 16'hffff)
        else $error("data line output enable active");
    a_monitor_trig_off: assert property ((!capture_run && monitor_run)[*6] |-> !trig_enable)
        else $error("trigger enabled during monitor");
    a_pll_decision: assert property (idle_apply |-> ##3 pll_enable ==
        $past(pll_want, 3))
        else $error("pll enable wrong after apply");
    a_dedicated_clock_input_pin_line: assert property (idle_apply |-> ##3 rev1_dedicated_clock_input_pin_reserved ==
        (!$past(cfg_int_clk, 3) && $past(rev1_pin, 5)))
        else $error("clock input line reservation wrong");
    a_dedicated_clock_output_pin_line: assert property (idle_apply |-> ##3 rev1_dedicated_clock_output_pin_reserved ==
        ($past(cfg_out_en, 3) && $past(rev1_pin, 5)))
        else $error("clock output line reservation wrong");
    a_outclk_off: assert property (idle_apply && !cfg_out_en |-> ##6
        (dedicated_clock_output_oe_n && rev1_clock_output_oe_n))
        else $error("output clock driven while disabled");
    a_outclk_pin: assert property (idle_apply && cfg_out_en |-> ##6
        rev1_clock_output_oe_n == !$past(rev1_pin, 8))
        else $error("output clock on wrong pin");
    a_monitor_period: assert property (hs && mon_q && monitor_run |->
        cnt_q == MONITOR_CYCLES - 1)
        else $error("monitor sample spacing wrong");
endmodule

bind acs_clock_sampler acs_clock_sampler_monitor #(.MONITOR_CYCLES(MONITOR_CYCLES))
    acs_clock_sampler_monitor_inst (.sys_clk, .reset, .cfg_apply, .cfg_int_clk, .cfg_freq_khz,
    .cfg_force_pll_off, .cfg_out_en, .capture_run, .monitor_run, .hw_rev, .data_pin_oe_n,
    .dedicated_clock_output_oe_n, .rev1_clock_output_oe_n, .pll_enable, .trig_enable,
    .rev1_dedicated_clock_input_pin_reserved, .rev1_dedicated_clock_output_pin_reserved, .busy, .smp_valid, .smp_ready);
`default_nettype wire

// >>> acs_clock_sampler_tb.sv
// Self-checking testbench for the clock and sampling block
`timescale 1ns/1ps
`default_nettype none
module acs_clock_sampler_tb;
    localparam int MON = 50;
    logic sys_clk, reset, cfg_apply, cfg_int_clk, cfg_force_pll_off, cfg_fall_sample;
    logic cfg_out_en, cfg_out_invert, cfg_ext_trig_en, capture_run, monitor_run, ext_en;
    logic smp_ready, smp_valid, busy, overflow, pll_enable, trig_enable;
    logic rev1_dedicated_clock_input_pin_reserved, rev1_dedicated_clock_output_pin_reserved, dedicated_clock_input_pin;
    logic rev1_ext_clock_input_line, dedicated_clock_output_pin, dedicated_clock_output_oe_n;
    logic rev1_clock_output_line, rev1_clock_output_oe_n;
    logic [acs_pkg::DIV_W-1:0] cfg_div_ratio;
    logic [acs_pkg::FREQ_W-1:0] cfg_freq_khz;
    logic [15:0] cfg_out_ratio, cfg_data_mask, data_pin_in, data_pin_oe_n, smp_data, mask_app;
    logic [7:0] hw_rev;
    int fails, comparisons, p, i;

    acs_target_model acs_target_model_inst (.ext_en, .rev(hw_rev),
        .ded_clk(dedicated_clock_input_pin), .line_clk(rev1_ext_clock_input_line),
        .data(data_pin_in));
    acs_clock_sampler #(.MONITOR_CYCLES(MON)) acs_clock_sampler_inst (.sys_clk, .reset,
        .cfg_apply, .cfg_int_clk, .cfg_div_ratio, .cfg_freq_khz, .cfg_force_pll_off,
        .cfg_fall_sample, .cfg_out_en, .cfg_out_ratio, .cfg_out_invert, .cfg_data_mask,
        .cfg_ext_trig_en, .capture_run, .monitor_run, .hw_rev, .data_pin_in, .data_pin_oe_n,
        .dedicated_clock_input_pin, .rev1_ext_clock_input_line, .dedicated_clock_output_pin,
        .dedicated_clock_output_oe_n, .rev1_clock_output_line, .rev1_clock_output_oe_n,
        .pll_enable, .trig_enable, .rev1_dedicated_clock_input_pin_reserved, .rev1_dedicated_clock_output_pin_reserved, .busy,
        .overflow, .smp_valid, .smp_data, .smp_ready);

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic test_done;
        if (fails == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic apply;
        cfg_apply = 1'b1;
        mask_app = cfg_data_mask;
        tick(1);
        cfg_apply = 1'b0;
        tick(8);
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return smp_valid;
            1: return dedicated_clock_output_pin;
            default: return rev1_clock_output_line;
        endcase
    endfunction

    // Cycles between two rising edges of the chosen signal, bounded
    task automatic gap(input int s, output int per);
        int t;
        logic prev;
        logic cur;
        t = -1;
        per = 0;
        prev = pick(s);
        for (int k = 0; k < 400; k++) begin
            tick(1);
            cur = pick(s);
            if (s == 0 && cur === 1'b1) begin
                chk("masked_lines", 32'h0, {16'h0, smp_data & ~mask_app});
            end
            if (cur === 1'b1 && prev === 1'b0) begin
                if (t >= 0) begin
                    per = k - t;
                    return;
                end
                t = k;
            end
            prev = cur;
        end
        fails++;
        test_done();
    endtask

    task automatic cap(input int s, input int exp, input string name);
        capture_run = 1'b1;
        gap(s, p);
        chk(name, exp, p);
        capture_run = 1'b0;
        tick(6);
    endtask

    initial begin
        fails = 0;
        comparisons = 0;
        {reset, cfg_int_clk, smp_ready} = 3'h7;
        {cfg_apply, cfg_force_pll_off, cfg_fall_sample, cfg_out_en} = 4'h0;
        {cfg_out_invert, cfg_ext_trig_en, capture_run, monitor_run, ext_en} = 5'h0;
        cfg_div_ratio = acs_pkg::DIV_W'(2);
        cfg_freq_khz = 20'h186a0;
        cfg_out_ratio = 16'h0001;
        cfg_data_mask = 16'h0ff0;
        mask_app = acs_pkg::MASK_RESET;
        hw_rev = 8'h02;
        tick(20);
        reset = 1'b0;
        chk("pll_enable", 32'h0, {31'h0, pll_enable});
        chk("data_oe_n", 32'hffff, {16'h0, data_pin_oe_n});
        chk("dedicated_clock_output_pin_oe_n", 32'h1, {31'h0, dedicated_clock_output_oe_n});
        cap(0, 2, "reset_clock");
        for (i = 0; i < 3; i++) begin
            cfg_div_ratio = acs_pkg::DIV_W'(i * 4 - (i > 0));
            apply();
            cap(0, (i == 0) ? 2 : i * 4 - 1, "int_divider");
        end
        for (i = 0; i < 3; i++) begin
            cfg_freq_khz = (i == 1) ? 20'h0464f : 20'h04650;
            cfg_force_pll_off = (i == 2);
            apply();
            chk("pll_enable", 32'(i == 0), {31'h0, pll_enable});
        end
        cfg_force_pll_off = 1'b0;
        ext_en = 1'b1;
        cfg_int_clk = 1'b0;
        cfg_freq_khz = 20'h061a8;
        apply();
        cap(0, 8, "ext_clock");
        hw_rev = 8'h01;
        cfg_out_en = 1'b1;
        cfg_out_ratio = 16'h0002;
        tick(6);
        apply();
        chk("dedicated_clock_input_pin_reserved", 32'h1, {31'h0, rev1_dedicated_clock_input_pin_reserved});
        chk("dedicated_clock_output_pin_reserved", 32'h1, {31'h0, rev1_dedicated_clock_output_pin_reserved});
        chk("line_oe_n", 32'h0, {31'h0, rev1_clock_output_oe_n});
        cap(0, 8, "line_ext_clock");
        cap(2, 16, "line_out_clock");
        hw_rev = 8'h02;
        ext_en = 1'b0;
        cfg_int_clk = 1'b1;
        cfg_div_ratio = acs_pkg::DIV_W'(4);
        cfg_out_ratio = 16'h0003;
        tick(6);
        apply();
        chk("dedicated_clock_input_pin_reserved", 32'h0, {31'h0, rev1_dedicated_clock_input_pin_reserved});
        chk("ded_oe_n", 32'h0, {31'h0, dedicated_clock_output_oe_n});
        cap(1, 12, "out_ratio");
        cfg_out_ratio = 16'h0001;
        cfg_out_invert = 1'b1;
        cfg_fall_sample = 1'b1;
        apply();
        cap(1, 4, "out_invert");
        cap(0, 4, "fall_sample");
        cfg_out_en = 1'b0;
        cfg_ext_trig_en = 1'b1;
        apply();
        chk("ded_oe_n", 32'h1, {31'h0, dedicated_clock_output_oe_n});
        monitor_run = 1'b1;
        gap(0, p);
        chk("monitor_period", MON, p);
        chk("trig_enable", 32'h0, {31'h0, trig_enable});
        monitor_run = 1'b0;
        tick(6);
        capture_run = 1'b1;
        tick(6);
        chk("trig_enable", 32'h1, {31'h0, trig_enable});
        capture_run = 1'b0;
        cfg_div_ratio = acs_pkg::DIV_W'(2);
        tick(6);
        apply();
        smp_ready = 1'b0;
        capture_run = 1'b1;
        tick(80);
        chk("overflow", 32'h1, {31'h0, overflow});
        chk("busy", 32'h1, {31'h0, busy});
        capture_run = 1'b0;
        tick(4);
        smp_ready = 1'b1;
        p = 0;
        repeat (40) begin
            p += (smp_valid === 1'b1);
            tick(1);
        end
        chk("fifo_words", 17, p);
        apply();
        chk("overflow", 32'h0, {31'h0, overflow});
        test_done();
    end
endmodule
`default_nettype wire

// >>> acs_fifo.sv
// Sample FIFO with registered output stage
`timescale 1ns/1ps
`default_nettype none
module acs_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Streams
    acs_stream_if.consumer wr,
    acs_stream_if.producer rd
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [CW-1:0] cnt_q;
    logic [W-1:0] out_q;
    logic out_v_q;
    logic push;
    logic pop;

    assign wr.ready = (cnt_q != CW'(DEPTH));
    assign push = wr.valid && wr.ready;
    assign pop = (cnt_q != '0) && (!out_v_q || rd.ready);
    assign rd.valid = out_v_q;
    assign rd.data = out_q;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= wr.data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == LAST) ? '0 : wp_q + AW'(1);
            end
            if (pop) begin
                rp_q <= (rp_q == LAST) ? '0 : rp_q + AW'(1);
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + CW'(1);
            end else if (pop && !push) begin
                cnt_q <= cnt_q - CW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            out_q <= '0;
            out_v_q <= 1'b0;
        end else if (pop) begin
            out_q <= mem_q[rp_q];
            out_v_q <= 1'b1;
        end else if (rd.ready) begin
            out_v_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> acs_pkg.sv
// Shared constants for the analyser clock and sampling set-up block
// Contract
// - Internal clock is integer division of reference
// - Divider period resolution is one fixed step
// - External mode uses user clock, no divider
// - Reset selects internal reference clock
// - Rev 01 reserves control line for clock input
// - PLL only between maximum and 18 MHz
// - Force-off disables PLL, else automatic
// - Sample on falling edge when selected
// - Rev 01 reserves control line for output clock
// - Output clock disabled drives nothing
// - Output clock is operating clock over 1..65535
// - Inversion moves output clock to falling edge
// - Per-line data mask, disabled lines undriven
// - Monitor samples enabled lines every 100 ms
// - Monitor forces external triggering off
package acs_pkg;
    localparam int REF_MHZ = 200;
    localparam int SYS_PERIOD_PS = 5000;
    localparam int DIV_STEP_NS = 4;
    localparam int MIN_OP_HZ = 800;
    localparam int DIV_W = $clog2(REF_MHZ * 1000000 / MIN_OP_HZ + 1);
    localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(2);
    localparam logic [DIV_W-1:0] DIV_RESET = DIV_W'(2);
    localparam int FREQ_W = 20;
    localparam logic [FREQ_W-1:0] PLL_MIN_KHZ = FREQ_W'(18000);
    localparam int RATIO_W = 16;
    localparam logic [RATIO_W-1:0] RATIO_RESET = 16'h0001;
    localparam int DATA_W = 16;
    localparam logic [DATA_W-1:0] MASK_RESET = 16'hffff;
    localparam int FIFO_DEPTH = 16;
    localparam int REV_W = 8;
    localparam logic [REV_W-1:0] REV_FIRST = 8'h01;
    localparam logic [REV_W-1:0] REV_DEDICATED = 8'h02;
    localparam logic [REV_W-1:0] REV_RESET = 8'h02;
    localparam int MONITOR_MS = 100;
    localparam int MONITOR_CYCLES = MONITOR_MS * (1000000000 / SYS_PERIOD_PS);
    typedef enum logic [2:0] {
        ACS_IDLE = 3'b001,
        ACS_CAPTURE = 3'b010,
        ACS_MONITOR = 3'b100
    } acs_state_e;
endpackage

// >>> acs_stream_if.sv
// Valid/ready sample stream between sampler and buffer
`timescale 1ns/1ps
`default_nettype none
interface acs_stream_if #(parameter int W = 16) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport producer (output valid, output data, input ready);
    modport consumer (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> acs_target_model.sv
// Target-system model driving the data lines and the external clock
`timescale 1ns/1ps
`default_nettype none
module acs_target_model (
    // Control from the bench
    input wire logic ext_en,
    input wire logic [7:0] rev,
    // Connector pins
    output logic ded_clk,
    output logic line_clk,
    output logic [15:0] data
);
    logic ck;

    // Clock of 40 ns, out of phase with the bench clock, still while disabled
    initial begin
        ck = 1'b0;
        data = 16'h0;
        #1.3;
        forever begin
            #20 ck = ext_en && !ck;
            data = data + 16'h1357;
        end
    end

    // Revision 01 takes the clock on a control line
    assign ded_clk = (rev != 8'h01) && ck;
    assign line_clk = (rev == 8'h01) && ck;
endmodule
`default_nettype wire
